// *** design/abk_break_unit.sv ***
// Address break comparator with its register file and interrupt outputs.
//
// Function
// RULE1 - Break request ignores the CPU global interrupt mask bit.
// RULE2 - Break on instruction execution or on data access with data match.
// RULE3 - Unmask bit resets 1; when 0, interrupts held after return one instruction.
// RULE4 - Cycle select picks execution, data read, data write or either.
// RULE5 - Address compare uses 16, upper 12, 8 or 4 bits; 1XX reserved.
// RULE6 - Data compare: none, low byte, high byte or full word.
// RULE7 - Memory word even uses upper lane, odd lower, bytes always upper.
// RULE8 - Byte-wide I/O registers always use the upper data lane.
// RULE9 - Word-wide I/O registers: even address upper lane, odd lower.
// RULE10 - Break flag resets 0 and sets when the programmed condition matches.
// RULE11 - Flag clears only by writing 0 after reading it as 1.
// RULE12 - Interrupt enable bit resets 0 and lets the request reach the CPU.
// RULE13 - Status bits 5 to 0 always read as 1.
// RULE14 - Break address is 16 bits, read/write by bytes, resets to all ones.
// RULE15 - Software loads the first byte address for execution breaks.
// RULE16 - Break data high byte meets upper lane, low byte meets lower lane.
// RULE17 - Software puts byte comparison values in the high data byte.
// RULE18 - Break request is driven exactly while flag and enable are both 1; the code registers it, so it follows them one clock later.
// RULE19 - Writing 1, or 0 without a prior read of 1, leaves the flag.
`timescale 1ns/1ns
module abk_break_unit (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire abk_pkg::abk_reg_req_t i_req,
  output logic [7:0]                 o_rdata,
  input  wire abk_pkg::abk_cpu_bus_t i_cpu_bus,
  input  wire logic                  i_cpu_rte,
  input  wire logic                  i_cpu_insn_done,
  output logic                       o_break_irq,
  output logic                       o_rte_irq_hold,
  output logic                       o_irq
);

  logic [7:0]  ctrl_q;
  logic        flag_q;
  logic        irq_en_q;
  logic        flag_read_q;
  logic [15:0] brk_addr_q;
  logic [15:0] brk_data_q;
  logic [abk_pkg::ABK_EVT_W-1:0] evt_q;
  logic [abk_pkg::ABK_EVT_W-1:0] mask_q;

  abk_pkg::abk_cyc_t  csel;
  abk_pkg::abk_dcmp_t dcmp;
  logic [2:0]  acmp;
  logic [15:0] addr_mask;
  logic        addr_ok;
  logic        cyc_ok;
  logic        lane_lo;
  logic        data_ok;
  logic        match;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        rd_stat;
  logic        flag_clr;

  assign csel = abk_pkg::abk_cyc_t'(ctrl_q[abk_pkg::ABK_CTRL_CSEL_LSB +: 2]);
  assign dcmp = abk_pkg::abk_dcmp_t'(ctrl_q[abk_pkg::ABK_CTRL_DCMP_LSB +: 2]);
  assign acmp = ctrl_q[abk_pkg::ABK_CTRL_ACMP_LSB +: 3];

  assign wr_ctrl = i_req.wr && (i_req.addr == abk_pkg::ABK_CTRL_IDX);
  assign wr_stat = i_req.wr && (i_req.addr == abk_pkg::ABK_STAT_IDX);
  assign rd_stat = i_req.rd && (i_req.addr == abk_pkg::ABK_STAT_IDX);

  // Reserved codes compare nothing, so a break never fires on them.
  always_comb begin
    addr_mask = 16'h0000;
    addr_ok   = 1'b0;
    unique case (acmp)
      3'b000: addr_mask = 16'hFFFF; // RULE5
      3'b001: addr_mask = 16'hFFF0; // RULE5
      3'b010: addr_mask = 16'hFF00; // RULE5
      3'b011: addr_mask = 16'hF000; // RULE5
      default: addr_mask = 16'h0000;
    endcase
    if (!acmp[2]) begin
      addr_ok = ((i_cpu_bus.addr ^ brk_addr_q) & addr_mask) == 16'h0000;
    end
  end

  always_comb begin
    cyc_ok = 1'b0;
    unique case (csel)
      abk_pkg::ABK_CYC_EXEC:  cyc_ok = i_cpu_bus.exec; // RULE4
      abk_pkg::ABK_CYC_READ:  cyc_ok = i_cpu_bus.read; // RULE4
      abk_pkg::ABK_CYC_WRITE: cyc_ok = i_cpu_bus.write; // RULE4
      abk_pkg::ABK_CYC_RDWR:  cyc_ok = i_cpu_bus.read || i_cpu_bus.write;
    endcase
  end

  // Only word cycles at odd addresses to memory or word-wide I/O use
  // the lower lane; byte cycles and byte-wide I/O always use the upper.
  assign lane_lo = i_cpu_bus.word && i_cpu_bus.addr[0] &&
                   (i_cpu_bus.space != abk_pkg::ABK_SPC_IO8); // RULE7 RULE8 RULE9

  always_comb begin
    data_ok = 1'b0;
    unique case (dcmp)
      abk_pkg::ABK_DCMP_NONE: data_ok = 1'b1;
      abk_pkg::ABK_DCMP_LOW:
        data_ok = lane_lo &&
                  (i_cpu_bus.data[7:0] == brk_data_q[7:0]); // RULE6 RULE16
      abk_pkg::ABK_DCMP_HIGH:
        data_ok = !lane_lo &&
                  (i_cpu_bus.data[15:8] == brk_data_q[15:8]); // RULE6 RULE16
      abk_pkg::ABK_DCMP_WORD:
        data_ok = i_cpu_bus.data == brk_data_q; // RULE6
    endcase
  end

  // Execution breaks look at the address only; data is not on the bus.
  assign match = i_cpu_bus.valid && cyc_ok && addr_ok &&
                 ((csel == abk_pkg::ABK_CYC_EXEC) || data_ok); // RULE2

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= abk_pkg::ABK_CTRL_RST; // RULE3
    end else if (wr_ctrl) begin
      ctrl_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      brk_addr_q <= abk_pkg::ABK_ADDR_RST; // RULE14
      brk_data_q <= abk_pkg::ABK_DATA_RST;
    end else if (i_req.wr) begin
      if (i_req.addr == abk_pkg::ABK_ADDR_HI_IDX) begin
        brk_addr_q[15:8] <= i_req.wdata; // RULE14
      end
      if (i_req.addr == abk_pkg::ABK_ADDR_LO_IDX) begin
        brk_addr_q[7:0] <= i_req.wdata; // RULE14
      end
      if (i_req.addr == abk_pkg::ABK_DATA_HI_IDX) begin
        brk_data_q[15:8] <= i_req.wdata; // RULE16
      end
      if (i_req.addr == abk_pkg::ABK_DATA_LO_IDX) begin
        brk_data_q[7:0] <= i_req.wdata; // RULE16
      end
    end
  end

  // A read of the flag as 1 arms the clear; any status write disarms it.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_read_q <= 1'b0;
    end else if (wr_stat) begin
      flag_read_q <= 1'b0;
    end else if (rd_stat && flag_q) begin
      flag_read_q <= 1'b1; // RULE11
    end
  end

  assign flag_clr = wr_stat && flag_read_q &&
                    !i_req.wdata[abk_pkg::ABK_STAT_FLAG_BIT]; // RULE11 RULE19

  // A match in the clearing cycle wins, so no break is lost.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else if (match) begin
      flag_q <= 1'b1; // RULE10
    end else if (flag_clr) begin
      flag_q <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= 1'b0; // RULE12
    end else if (wr_stat) begin
      irq_en_q <= i_req.wdata[abk_pkg::ABK_STAT_IE_BIT]; // RULE12
    end
  end

  // The request has no path through the CPU global mask; it is an NMI
  // class source, so the CPU must accept it regardless of that bit.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_break_irq <= 1'b0;
    end else begin
      o_break_irq <= flag_q && irq_en_q; // RULE18 RULE1 RULE12
    end
  end

  // Interrupt hold after a return: set by the return, released by the
  // next completed instruction, never set while the unmask bit is 1.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rte_irq_hold <= 1'b0;
    end else if (ctrl_q[abk_pkg::ABK_CTRL_UNMASK_BIT]) begin
      o_rte_irq_hold <= 1'b0; // RULE3
    end else if (i_cpu_rte) begin
      o_rte_irq_hold <= 1'b1; // RULE3
    end else if (i_cpu_insn_done) begin
      o_rte_irq_hold <= 1'b0; // RULE3
    end
  end

  // Sticky events: write one to clear, a new event wins over the clear.
  logic [abk_pkg::ABK_EVT_W-1:0] evt_set;
  logic [abk_pkg::ABK_EVT_W-1:0] evt_clr;

  assign evt_set = {match && flag_q, match};
  assign evt_clr = (i_req.wr && (i_req.addr == abk_pkg::ABK_EVT_IDX)) ?
                   i_req.wdata[abk_pkg::ABK_EVT_W-1:0] :
                   {abk_pkg::ABK_EVT_W{1'b0}};

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_q <= '0;
    end else if (i_req.wr && (i_req.addr == abk_pkg::ABK_MASK_IDX)) begin
      mask_q <= i_req.wdata[abk_pkg::ABK_EVT_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_q & mask_q);
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        abk_pkg::ABK_CTRL_IDX:    o_rdata <= ctrl_q;
        abk_pkg::ABK_STAT_IDX:
          o_rdata <= {flag_q, irq_en_q, abk_pkg::ABK_STAT_RSV_BITS}; // RULE13
        abk_pkg::ABK_ADDR_HI_IDX: o_rdata <= brk_addr_q[15:8];
        abk_pkg::ABK_ADDR_LO_IDX: o_rdata <= brk_addr_q[7:0];
        abk_pkg::ABK_DATA_HI_IDX: o_rdata <= brk_data_q[15:8];
        abk_pkg::ABK_DATA_LO_IDX: o_rdata <= brk_data_q[7:0];
        abk_pkg::ABK_EVT_IDX:     o_rdata <= {6'h00, evt_q};
        abk_pkg::ABK_MASK_IDX:    o_rdata <= {6'h00, mask_q};
        default:                  o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  flag_on_match_a: assert property ( // RULE10
    match |=> flag_q ##1 o_break_irq == $past(irq_en_q))
    else $error("Break flag or request missing after a match.");

  irq_follows_a: assert property ( // RULE18
    (flag_q && irq_en_q) |=> o_break_irq)
    else $error("Break request low while flag and enable are set.");

  irq_quiet_a: assert property ( // RULE18
    !(flag_q && irq_en_q) |=> !o_break_irq)
    else $error("Break request high without flag and enable.");

  status_ones_a: assert property ( // RULE13
    rd_stat |=> o_rdata[5:0] == 6'h3F && o_rdata[7] == $past(flag_q))
    else $error("Status read shows wrong reserved or flag bits.");

  clear_armed_a: assert property ( // RULE11
    (rd_stat && flag_q && !wr_stat) ##1
    (wr_stat && !i_req.wdata[7] && !match) |=> !flag_q)
    else $error("Flag not cleared by write 0 after read of 1.");

  clear_refused_a: assert property ( // RULE19
    (flag_q && wr_stat && !flag_read_q) |=> flag_q)
    else $error("Flag cleared without a preceding read of 1.");

  addr_nibble_a: assert property ( // RULE5
    (match && acmp == 3'b011) |->
    i_cpu_bus.addr[15:12] == brk_addr_q[15:12])
    else $error("Upper nibble compare matched a wrong address.");

  reserved_acmp_a: assert property ( // RULE5
    acmp[2] |-> !match)
    else $error("Reserved address compare code produced a match.");

  cycle_read_a: assert property ( // RULE4
    (match && csel == abk_pkg::ABK_CYC_READ) |-> i_cpu_bus.read)
    else $error("Read-cycle break fired on a non-read cycle.");

  rte_hold_a: assert property ( // RULE3
    (i_cpu_rte && !ctrl_q[7]) |=> o_rte_irq_hold)
    else $error("Interrupt hold not set after a return.");

  rte_free_a: assert property ( // RULE3
    ctrl_q[7] |=> !o_rte_irq_hold)
    else $error("Interrupt hold set while unmask bit is 1.");

  byte_lane_a: assert property ( // RULE7
    (match && dcmp == abk_pkg::ABK_DCMP_HIGH && !i_cpu_bus.word &&
     csel != abk_pkg::ABK_CYC_EXEC) |->
    i_cpu_bus.data[15:8] == brk_data_q[15:8])
    else $error("Byte access data break used the wrong lane.");

  exec_cycle_a: assert property ( // RULE2
    (match && csel == abk_pkg::ABK_CYC_EXEC) |-> i_cpu_bus.exec)
    else $error("Execution break fired on a non-execution cycle.");

  cycle_write_a: assert property ( // RULE4
    (match && csel == abk_pkg::ABK_CYC_WRITE) |-> i_cpu_bus.write)
    else $error("Write-cycle break fired on a non-write cycle.");

  cycle_either_a: assert property ( // RULE4
    (match && csel == abk_pkg::ABK_CYC_RDWR) |->
    (i_cpu_bus.read || i_cpu_bus.write))
    else $error("Data-cycle break fired without a data access.");

  addr_full_a: assert property ( // RULE5
    (match && acmp == 3'b000) |-> i_cpu_bus.addr == brk_addr_q)
    else $error("Full address compare matched a wrong address.");

  addr_twelve_a: assert property ( // RULE5
    (match && acmp == 3'b001) |->
    i_cpu_bus.addr[15:4] == brk_addr_q[15:4])
    else $error("Upper 12-bit compare matched a wrong address.");

  addr_byte_a: assert property ( // RULE5
    (match && acmp == 3'b010) |->
    i_cpu_bus.addr[15:8] == brk_addr_q[15:8])
    else $error("Upper byte compare matched a wrong address.");

  word_data_a: assert property ( // RULE6
    (match && dcmp == abk_pkg::ABK_DCMP_WORD &&
     csel != abk_pkg::ABK_CYC_EXEC) |-> i_cpu_bus.data == brk_data_q)
    else $error("Word data break matched wrong data.");

  low_lane_a: assert property ( // RULE9
    (match && dcmp == abk_pkg::ABK_DCMP_LOW &&
     csel != abk_pkg::ABK_CYC_EXEC) |->
    (i_cpu_bus.word && i_cpu_bus.addr[0] &&
     i_cpu_bus.data[7:0] == brk_data_q[7:0]))
    else $error("Lower byte data break used the wrong lane.");

  io8_upper_a: assert property ( // RULE8
    (match && dcmp == abk_pkg::ABK_DCMP_LOW &&
     csel != abk_pkg::ABK_CYC_EXEC) |->
    i_cpu_bus.space != abk_pkg::ABK_SPC_IO8)
    else $error("Lower byte data break fired on a byte-wide register.");

  write_one_a: assert property ( // RULE19
    (flag_q && wr_stat && i_req.wdata[7]) |=> flag_q)
    else $error("Writing 1 to the break flag cleared it.");

  enable_load_a: assert property ( // RULE12
    wr_stat |=> irq_en_q == $past(i_req.wdata[6]))
    else $error("Interrupt enable bit not loaded by a status write.");

  rte_release_a: assert property ( // RULE3
    (o_rte_irq_hold && i_cpu_insn_done && !i_cpu_rte) |=>
    !o_rte_irq_hold)
    else $error("Interrupt hold not released after one instruction.");

  addr_bytes_a: assert property ( // RULE14
    (i_req.wr && i_req.addr == abk_pkg::ABK_ADDR_LO_IDX) |=>
    brk_addr_q[7:0] == $past(i_req.wdata))
    else $error("Break address low byte not written.");

  data_bytes_a: assert property ( // RULE16
    (i_req.wr && i_req.addr == abk_pkg::ABK_DATA_HI_IDX) |=>
    brk_data_q[15:8] == $past(i_req.wdata))
    else $error("Break data high byte not written.");

  exec_break_c: cover property (
    i_cpu_bus.exec && csel == abk_pkg::ABK_CYC_EXEC && match);
  word_break_c: cover property (
    match && dcmp == abk_pkg::ABK_DCMP_WORD && i_cpu_bus.write);
  flag_cleared_c: cover property (flag_q && flag_clr ##1 !flag_q);
  set_beats_clr_c: cover property (match && flag_clr);
  rte_hold_c: cover property (i_cpu_rte && !ctrl_q[7] ##1 o_rte_irq_hold);

endmodule

// *** design/abk_pkg.sv ***
// Package with the address break unit's register map, fields and types.
package abk_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ABK_CTRL_IDX    = 4'h0;
  localparam logic [3:0] ABK_STAT_IDX    = 4'h1;
  localparam logic [3:0] ABK_ADDR_HI_IDX = 4'h2;
  localparam logic [3:0] ABK_ADDR_LO_IDX = 4'h3;
  localparam logic [3:0] ABK_DATA_HI_IDX = 4'h4;
  localparam logic [3:0] ABK_DATA_LO_IDX = 4'h5;
  localparam logic [3:0] ABK_EVT_IDX     = 4'h6;
  localparam logic [3:0] ABK_MASK_IDX    = 4'h7;

  // Control field positions.
  localparam int ABK_CTRL_UNMASK_BIT = 7;
  localparam int ABK_CTRL_CSEL_LSB   = 5;
  localparam int ABK_CTRL_ACMP_LSB   = 2;
  localparam int ABK_CTRL_DCMP_LSB   = 0;

  // Status field positions.
  localparam int ABK_STAT_FLAG_BIT = 7;
  localparam int ABK_STAT_IE_BIT   = 6;

  // Values after reset.
  localparam logic [7:0]  ABK_CTRL_RST      = 8'h80;
  localparam logic [15:0] ABK_ADDR_RST      = 16'hFFFF;
  localparam logic [15:0] ABK_DATA_RST      = 16'h0000;
  localparam logic [5:0]  ABK_STAT_RSV_BITS = 6'h3F;

  // Event bits of the sticky event register.
  localparam int ABK_EVT_MATCH   = 0;
  localparam int ABK_EVT_OVERRUN = 1;
  localparam int ABK_EVT_W       = 2;

  typedef enum logic [1:0] {
    ABK_CYC_EXEC  = 2'b00,
    ABK_CYC_READ  = 2'b01,
    ABK_CYC_WRITE = 2'b10,
    ABK_CYC_RDWR  = 2'b11
  } abk_cyc_t;

  typedef enum logic [1:0] {
    ABK_DCMP_NONE = 2'b00,
    ABK_DCMP_LOW  = 2'b01,
    ABK_DCMP_HIGH = 2'b10,
    ABK_DCMP_WORD = 2'b11
  } abk_dcmp_t;

  // Kind of space that a bus cycle reaches.
  typedef enum logic [1:0] {
    ABK_SPC_MEM  = 2'b00,
    ABK_SPC_IO8  = 2'b01,
    ABK_SPC_IO16 = 2'b10
  } abk_space_t;

  // One monitored CPU bus cycle.
  typedef struct packed {
    logic        valid;
    logic        exec;
    logic        read;
    logic        write;
    logic        word;
    abk_space_t  space;
    logic [15:0] addr;
    logic [15:0] data;
  } abk_cpu_bus_t;

  // Register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } abk_reg_req_t;

endpackage

// *** tb/abk_break_unit_bench.sv ***
// Self-checking bench for the address break unit.
`timescale 1ns/1ns
module abk_break_unit_bench;
  localparam logic [3:0] CT = abk_pkg::ABK_CTRL_IDX;
  localparam logic [3:0] ST = abk_pkg::ABK_STAT_IDX;
  localparam logic [3:0] EV = abk_pkg::ABK_EVT_IDX;
  localparam abk_pkg::abk_space_t MEM = abk_pkg::ABK_SPC_MEM;
  localparam abk_pkg::abk_space_t IO8 = abk_pkg::ABK_SPC_IO8;
  localparam abk_pkg::abk_space_t IO16 = abk_pkg::ABK_SPC_IO16;
  logic                  i_mclk = 1'b0;
  logic                  i_rst_n = 1'b0;
  abk_pkg::abk_reg_req_t i_req = '0;
  logic [7:0]            o_rdata;
  abk_pkg::abk_cpu_bus_t cpu_bus;
  logic                  cpu_rte;
  logic                  cpu_done;
  logic                  o_break_irq;
  logic                  o_rte_irq_hold;
  logic                  o_irq;
  int                    bad_count = 0;
  int                    check_count = 0;

  always #5 i_mclk = ~i_mclk;

  abk_break_unit abk_break_unit_inst (
    .i_mclk          (i_mclk),
    .i_rst_n         (i_rst_n),
    .i_req           (i_req),
    .o_rdata         (o_rdata),
    .i_cpu_bus       (cpu_bus),
    .i_cpu_rte       (cpu_rte),
    .i_cpu_insn_done (cpu_done),
    .o_break_irq     (o_break_irq),
    .o_rte_irq_hold  (o_rte_irq_hold),
    .o_irq           (o_irq)
  );

  abk_cpu_model abk_cpu_model_inst (
    .i_mclk      (i_mclk),
    .o_bus       (cpu_bus),
    .o_rte       (cpu_rte),
    .o_insn_done (cpu_done)
  );

  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    i_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_mclk);
    i_req <= '0;
    #1 check({8'h00, o_rdata}, {8'h00, exp});
  endtask

  // Status read followed at once by a clearing write, with no gap.
  task automatic rd_clear(input logic [7:0] exp);
    @(posedge i_mclk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: ST, wdata: 8'h00};
    @(posedge i_mclk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: ST, wdata: 8'h00};
    #1 check({8'h00, o_rdata}, {8'h00, exp});
    @(posedge i_mclk);
    i_req <= '0;
  endtask

  // Each hit writes the control byte, then clears a flag that the previous hit's read armed.
  task automatic hit(input logic [7:0] ctl, input logic ex, r, w, wd,
                     input abk_pkg::abk_space_t sp,
                     input logic [15:0] a, d, input logic exp);
    wr(CT, ctl);
    wr(ST, 8'h40);
    abk_cpu_model_inst.cycle(ex, r, w, wd, sp, a, d);
    @(posedge i_mclk);
    #1 check({15'h0000, o_break_irq}, {15'h0000, exp});
    rd(ST, {exp, 7'h7F});
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(CT, 8'h80);
    rd(ST, 8'h3F);
    rd(abk_pkg::ABK_ADDR_HI_IDX, 8'hFF);
    rd(abk_pkg::ABK_ADDR_LO_IDX, 8'hFF);
    rd(4'h8, 8'h00);
    wr(abk_pkg::ABK_ADDR_HI_IDX, 8'h12);
    wr(abk_pkg::ABK_ADDR_LO_IDX, 8'h34);
    wr(abk_pkg::ABK_DATA_HI_IDX, 8'h5A);
    wr(abk_pkg::ABK_DATA_LO_IDX, 8'hA5);
    rd(abk_pkg::ABK_ADDR_LO_IDX, 8'h34);
    rd(abk_pkg::ABK_DATA_HI_IDX, 8'h5A);
    hit(8'h80, 1, 0, 0, 0, MEM, 16'h1234, 16'h0000, 1);
    hit(8'h80, 1, 0, 0, 0, MEM, 16'h1235, 16'h0000, 0);
    hit(8'h84, 1, 0, 0, 0, MEM, 16'h123F, 16'h0000, 1);
    hit(8'h84, 1, 0, 0, 0, MEM, 16'h124F, 16'h0000, 0);
    hit(8'h88, 1, 0, 0, 0, MEM, 16'h12FF, 16'h0000, 1);
    hit(8'h8C, 1, 0, 0, 0, MEM, 16'h1FFF, 16'h0000, 1);
    hit(8'h8C, 1, 0, 0, 0, MEM, 16'h2234, 16'h0000, 0);
    hit(8'h90, 1, 0, 0, 0, MEM, 16'h1234, 16'h0000, 0);
    hit(8'h83, 1, 0, 0, 0, MEM, 16'h1234, 16'h0000, 1);
    hit(8'hA6, 0, 1, 0, 0, MEM, 16'h1235, 16'h5A00, 1);
    hit(8'hA6, 0, 1, 0, 0, MEM, 16'h1235, 16'h005A, 0);
    hit(8'hC6, 0, 0, 1, 0, MEM, 16'h1234, 16'h5A00, 1);
    hit(8'hC6, 0, 1, 0, 0, MEM, 16'h1234, 16'h5A00, 0);
    hit(8'hE7, 0, 1, 0, 1, MEM, 16'h1234, 16'h5AA5, 1);
    hit(8'hE7, 0, 0, 1, 1, MEM, 16'h1234, 16'h5AA4, 0);
    hit(8'hA5, 0, 1, 0, 1, MEM, 16'h1235, 16'h00A5, 1);
    hit(8'hA5, 0, 1, 0, 1, MEM, 16'h1234, 16'h00A5, 0);
    hit(8'hA5, 0, 1, 0, 1, IO16, 16'h1235, 16'h00A5, 1);
    hit(8'hA5, 0, 1, 0, 1, IO8, 16'h1234, 16'hA5A5, 0);
    hit(8'hA6, 0, 1, 0, 1, IO8, 16'h1234, 16'h005A, 1);
    wr(EV, 8'h03);
    wr(abk_pkg::ABK_MASK_IDX, 8'h01);
    hit(8'h80, 1, 0, 0, 0, MEM, 16'h1234, 16'h0000, 1);
    check({15'h0000, o_irq}, 16'h0001);
    abk_cpu_model_inst.cycle(1, 0, 0, 0, MEM, 16'h1234, 16'h0000);
    rd(EV, 8'h03);
    wr(EV, 8'h03);
    rd(EV, 8'h00);
    check({15'h0000, o_irq}, 16'h0000);
    wr(abk_pkg::ABK_MASK_IDX, 8'h00);
    abk_cpu_model_inst.cycle(1, 0, 0, 0, MEM, 16'h1234, 16'h0000);
    rd(EV, 8'h03);
    check({15'h0000, o_irq}, 16'h0000);
    rd(ST, 8'hFF);
    wr(ST, 8'h80);
    rd(ST, 8'hBF);
    check({15'h0000, o_break_irq}, 16'h0000);
    wr(ST, 8'h80);
    wr(ST, 8'h00);
    rd_clear(8'hBF);
    rd(ST, 8'h3F);
    wr(CT, 8'h00);
    abk_cpu_model_inst.pulse(1'b1);
    #1 check({15'h0000, o_rte_irq_hold}, 16'h0001);
    abk_cpu_model_inst.pulse(1'b0);
    #1 check({15'h0000, o_rte_irq_hold}, 16'h0000);
    wr(CT, 8'h80);
    abk_cpu_model_inst.pulse(1'b1);
    #1 check({15'h0000, o_rte_irq_hold}, 16'h0000);
    wrap_up();
  end
endmodule

// *** tb/abk_cpu_model.sv ***
// Behavioural CPU bus partner that presents monitored bus cycles.
`timescale 1ns/1ns
module abk_cpu_model (
  input  wire logic             i_mclk,
  output abk_pkg::abk_cpu_bus_t o_bus,
  output logic                  o_rte,
  output logic                  o_insn_done
);
  initial begin
    o_bus       = '0;
    o_rte       = 1'b0;
    o_insn_done = 1'b0;
  end

  // Released lanes show the inverse, so a stale value can never match.
  task automatic put(input logic ex, rd, wr, wd,
                     input abk_pkg::abk_space_t sp,
                     input logic [15:0] a, d);
    @(posedge i_mclk);
    o_bus <= {1'b1, ex, rd, wr, wd, sp, a, d};
    @(posedge i_mclk);
    o_bus <= {1'b0, 4'h0, sp, ~a, ~d};
  endtask

  task automatic cycle(input logic ex, rd, wr, wd,
                       input abk_pkg::abk_space_t sp,
                       input logic [15:0] a, d);
    if (wd && sp == abk_pkg::ABK_SPC_IO8) begin
      put(ex, rd, wr, 1'b0, sp, a, {d[15:8], ~d[7:0]});
      put(ex, rd, wr, 1'b0, sp, a + 16'h0001, {d[7:0], ~d[7:0]});
    end else begin
      put(ex, rd, wr, wd, sp, a, d);
    end
  endtask

  task automatic pulse(input logic return_from_exception);
    @(posedge i_mclk);
    o_rte       <= return_from_exception;
    o_insn_done <= ~return_from_exception;
    @(posedge i_mclk);
    o_rte       <= 1'b0;
    o_insn_done <= 1'b0;
  endtask
endmodule
